//--- hdl/rcrc_defines.vh
`ifndef RCRC_DEFINES_VH
`define RCRC_DEFINES_VH
// Register byte offsets
`define RCRC_OFF_CTRL      12'h000
`define RCRC_OFF_STATUS    12'h004
`define RCRC_OFF_FREQ      12'h008
`define RCRC_OFF_TRIM      12'h00C
`define RCRC_OFF_NVCFG     12'h010
`define RCRC_OFF_DIVCFG    12'h014
// Control register fields
`define RCRC_CTRL_AWAKE    0
`define RCRC_CTRL_PINFUNC  1
`define RCRC_CTRL_LPSRC    2
`define RCRC_CTRL_RESET    32'h0000_0001
// Status register fields
`define RCRC_ST_AWAKE      0
`define RCRC_ST_POL        1
`define RCRC_ST_COMB       2
`define RCRC_ST_CFGDONE    3
`define RCRC_ST_DETOK      4
`define RCRC_ST_SRC_LSB    5
`define RCRC_ST_LPSEL      7
// Frequency source codes
`define RCRC_SRC_DEFAULT   2'h0
`define RCRC_SRC_NVRAM     2'h1
`define RCRC_SRC_DETECT    2'h2
// Frequency in kHz
`define RCRC_FREQ_DEFAULT  32'h0000_4E20
`define RCRC_TRIM_RESET    16'h0000
// Low-power clock nominal rate in Hz, for detection window
`define RCRC_LPC_HZ        32768
`endif

//--- hdl/rcrc_ref_clock_request_control.v
// How it works
// [R1] Clock request is asserted while awake, deasserted while asleep.
// [R2] Polarity strap 0 gives active-low output, 1 gives active-high.
// [R3] Output pin can be handed to other pin functions.
// [R4] Combining gate is pure combinational pad logic, independent of core clock; here it sits beside the core, not in a pad ring.
// [R5] Combine strap high makes request input feed the combining gate.
// [R6] Combine strap low: output follows internal need, input ignored.
// [R7] Combine mode, polarity 1: output is input OR internal state.
// [R8] Combine mode, polarity 0: output is input AND NOT internal state.
// [R9] External input is never inverted; requester matches strap polarity.
// [R10] Requester always drives the input to a defined level.
// [R11] Reference frequency defaults to 20 MHz.
// [R12] At power-on, NVRAM settings for frequency and trim are loaded.
// [R13] Auto-detection counts reference cycles over low-power clock periods.
// [R14] Configured frequency drives the serial and PCM bit timing divider.
// [R15] Trim value fine-tunes the synthesized frequency output word.
// [R16] Trim comes from host write or NVRAM recall at power-on.
// [R17] Low-power timing uses external clock or internal oscillator.
// [R18] Internal low-power clock may be derived from the main clock.
// [R19] Internal request state comes straight from a register.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rcrc_defines.vh"

module rcrc_ref_clock_request_control #(
	parameter DET_PERIODS = 16,
	parameter LPC_DIV     = 610
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        request_polarity_strap,
	input  wire        request_combine_strap,
	input  wire        clk_req_in,
	output wire        clk_req_out,
	output wire        clk_req_oe,
	input  wire        nv_valid,
	input  wire        nv_freq_present,
	input  wire [31:0] nv_freq_khz,
	input  wire        nv_trim_present,
	input  wire [15:0] nv_trim,
	input  wire        low_power_clock_ext,
	input  wire        lpc_ext_present,
	output reg  [31:0] ref_freq_khz,
	output reg  [15:0] freq_trim,
	output wire [47:0] synth_word,
	output reg         bit_tick,
	output reg         lpc_tick,
	output reg         lpc_sel_ext
);

	// Pin and strap synchronisers; first stage feeds only the second.
	// NVRAM flags come from a loader outside this clock and are synchronised
	// too; the data words behind them are held stable while flagged
	reg [1:0] pol_sync_reg;
	reg [1:0] comb_sync_reg;
	reg [1:0] lpc_sync_reg;
	reg [1:0] lpcp_sync_reg;
	reg [1:0] nvv_sync_reg;
	reg [1:0] nvf_sync_reg;
	reg [1:0] nvt_sync_reg;
	reg       lpc_prev_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_sync_reg  <= 2'h0;
			comb_sync_reg <= 2'h0;
			lpc_sync_reg  <= 2'h0;
			lpcp_sync_reg <= 2'h0;
			nvv_sync_reg  <= 2'h0;
			nvf_sync_reg  <= 2'h0;
			nvt_sync_reg  <= 2'h0;
			lpc_prev_reg  <= 1'b0;
		end else begin
			pol_sync_reg  <= {pol_sync_reg[0], request_polarity_strap};
			comb_sync_reg <= {comb_sync_reg[0], request_combine_strap};
			lpc_sync_reg  <= {lpc_sync_reg[0], low_power_clock_ext};
			lpcp_sync_reg <= {lpcp_sync_reg[0], lpc_ext_present};
			nvv_sync_reg  <= {nvv_sync_reg[0], nv_valid};
			nvf_sync_reg  <= {nvf_sync_reg[0], nv_freq_present};
			nvt_sync_reg  <= {nvt_sync_reg[0], nv_trim_present};
			lpc_prev_reg  <= lpc_sync_reg[1];
		end
	end

	// Edge detector resets low, the idle level of an absent clock
	wire lpc_rise   = lpc_sync_reg[1] & ~lpc_prev_reg;
	// NVRAM words are trusted only while valid and their flag are both set
	wire nv_freq_ok = nvv_sync_reg[1] & nvf_sync_reg[1];
	wire nv_trim_ok = nvv_sync_reg[1] & nvt_sync_reg[1];

	// Straps are latched once after reset release, then held. The latch
	// waits until both synchroniser stages carry the pin level; an earlier
	// latch would capture the reset zeros instead of the strap
	localparam [1:0] STRAP_SETTLE = 2'h2;
	reg       pol_reg;
	reg       comb_reg;
	reg       strap_done_reg;
	reg [1:0] settle_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_reg        <= 1'b1;
			comb_reg       <= 1'b0;
			strap_done_reg <= 1'b0;
			settle_reg     <= 2'h0;
		end else if (!strap_done_reg) begin
			if (settle_reg == STRAP_SETTLE) begin
				pol_reg        <= pol_sync_reg[1]; // R2
				comb_reg       <= comb_sync_reg[1]; // R5
				strap_done_reg <= 1'b1;
			end else begin
				settle_reg <= settle_reg + 2'h1;
			end
		end
	end

	// Software registers
	reg [31:0] ctrl_reg;
	reg [7:0]  div_reg;
	reg        trim_wr_reg;
	reg [15:0] trim_wdata_reg;
	wire       wr_en = psel & penable & pwrite;
	wire       rd_en = psel & penable & ~pwrite;
	wire       hit_ctrl   = (paddr == `RCRC_OFF_CTRL);
	wire       hit_status = (paddr == `RCRC_OFF_STATUS);
	wire       hit_freq   = (paddr == `RCRC_OFF_FREQ);
	wire       hit_trim   = (paddr == `RCRC_OFF_TRIM);
	wire       hit_nvcfg  = (paddr == `RCRC_OFF_NVCFG);
	wire       hit_div    = (paddr == `RCRC_OFF_DIVCFG);
	wire       addr_ok    = hit_ctrl | hit_status | hit_freq | hit_trim | hit_nvcfg | hit_div;

	// Zero-wait slave: every access lands on its first access edge,
	// and an unmapped offset is refused with no register effect
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg       <= `RCRC_CTRL_RESET;
			div_reg        <= 8'h01;
			trim_wr_reg    <= 1'b0;
			trim_wdata_reg <= `RCRC_TRIM_RESET;
		end else begin
			trim_wr_reg <= 1'b0;
			if (wr_en && hit_ctrl) begin
				ctrl_reg <= {29'h0, pwdata[2:0]};
			end
			// A zero divisor would stall bit timing, so it is stored as one
			if (wr_en && hit_div) begin
				div_reg <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0]; // R14
			end
			// Host trim command, passed on as a one-cycle pulse; the
			// sequencer applies it only after boot so NVRAM trim is kept
			if (wr_en && hit_trim) begin
				trim_wr_reg    <= 1'b1; // R16
				trim_wdata_reg <= pwdata[15:0];
			end
		end
	end

	// Internal request state is a flop so the gate sees no glitch
	// Reset asleep; CTRL resets awake, so the request rises one cycle after reset release
	reg awake_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			awake_reg <= 1'b0;
		end else begin
			awake_reg <= ctrl_reg[`RCRC_CTRL_AWAKE]; // R1 R19
		end
	end

	// Combining gate; no clock in path so it works with a stopped core
	// Active high: either side requests; active low: either side low pulls the output low.
	// The input is never inverted, so the requester must match the strap.
	// Limitation: here the gate sits beside the core, not in a pad ring
	wire req_solo = pol_reg ? awake_reg : ~awake_reg; // R1 R2 R6
	wire req_comb = pol_reg ? (clk_req_in | awake_reg) : (clk_req_in & ~awake_reg); // R7 R8 R9
	assign clk_req_out = comb_reg ? req_comb : req_solo; // R4 R5 R6
	// Pin released for other functions when feature unused
	assign clk_req_oe = ~ctrl_reg[`RCRC_CTRL_PINFUNC]; // R3

	// Power-on configuration sequencer
	// IDLE waits for settled straps and flags, NV takes NVRAM values,
	// WAIT aligns to a low-power edge, CNT counts reference cycles,
	// DONE holds the result and accepts host trim writes
	localparam ST_IDLE = 3'h0;
	localparam ST_NV   = 3'h1;
	localparam ST_WAIT = 3'h2;
	localparam ST_CNT  = 3'h3;
	localparam ST_DONE = 3'h4;

	reg [2:0]  st_reg;
	reg [1:0]  src_reg;
	reg        det_ok_reg;
	reg [7:0]  per_cnt_reg;
	reg [31:0] ref_cnt_reg;

	// Count reference cycles across DET_PERIODS low-power periods, scale to kHz
	// The quotient fits 32 bits for any plausible count, so it is cut there
	wire [63:0] det_prod = ref_cnt_reg * `RCRC_LPC_HZ;
	wire [63:0] det_quo  = det_prod / (DET_PERIODS * 1000);
	wire [31:0] det_khz  = det_quo[31:0];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg       <= ST_IDLE;
			src_reg      <= `RCRC_SRC_DEFAULT;
			det_ok_reg   <= 1'b0;
			per_cnt_reg  <= 8'h00;
			ref_cnt_reg  <= 32'h0000_0000;
			ref_freq_khz <= `RCRC_FREQ_DEFAULT; // R11
			freq_trim    <= `RCRC_TRIM_RESET;
		end else begin
			case (st_reg)
				// Wait for settled straps and synchronised flags
				ST_IDLE: begin
					if (strap_done_reg) begin
						st_reg <= ST_NV;
					end
				end
				ST_NV: begin
					if (nv_freq_ok) begin
						ref_freq_khz <= nv_freq_khz; // R12
						src_reg      <= `RCRC_SRC_NVRAM;
					end
					if (nv_trim_ok) begin
						freq_trim <= nv_trim; // R12 R16
					end
					if (nv_freq_ok || !lpcp_sync_reg[1]) begin
						st_reg <= ST_DONE;
					end else begin
						st_reg <= ST_WAIT;
					end
				end
				// Align to a low-power edge; stalls if that clock stops
				ST_WAIT: begin
					if (lpc_rise) begin
						st_reg      <= ST_CNT;
						per_cnt_reg <= 8'h00;
						ref_cnt_reg <= 32'h0000_0000;
					end
				end
				// Reference cycles counted between low-power edges
				ST_CNT: begin
					ref_cnt_reg <= ref_cnt_reg + 32'h0000_0001; // R13
					if (lpc_rise) begin
						if (per_cnt_reg == DET_PERIODS[7:0] - 8'h01) begin
							ref_freq_khz <= det_khz; // R13
							src_reg      <= `RCRC_SRC_DETECT;
							det_ok_reg   <= 1'b1;
							st_reg       <= ST_DONE;
						end else begin
							per_cnt_reg <= per_cnt_reg + 8'h01;
						end
					end
				end
				// Host trim only once boot values are in place
				ST_DONE: begin
					if (trim_wr_reg) begin
						freq_trim <= trim_wdata_reg; // R16
					end
				end
				// Unused codes restart the sequence
				default: begin
					st_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Synth word: frequency scaled, plus signed trim in fine steps
	// A negative trim pulls the word just below the nominal value
	assign synth_word = {ref_freq_khz, 16'h0000} + {{32{freq_trim[15]}}, freq_trim}; // R15

	// Bit-timing divider from configured frequency
	// A larger divisor acts at once: a count already at or past the new limit wraps on the next edge
	reg [31:0] bit_cnt_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_reg <= 32'h0000_0000;
			bit_tick    <= 1'b0;
		end else begin
			bit_tick <= 1'b0;
			if (bit_cnt_reg >= (ref_freq_khz >> 4) / {24'h0, div_reg}) begin
				bit_cnt_reg <= 32'h0000_0000;
				bit_tick    <= 1'b1; // R14
			end else begin
				bit_cnt_reg <= bit_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// Low-power timing source: external clock edges or divided main clock
	// Dividing the main clock spares an oscillator but costs sleep current
	reg [15:0] lpc_div_reg;
	wire       use_ext = ctrl_reg[`RCRC_CTRL_LPSRC] & lpcp_sync_reg[1];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpc_div_reg <= 16'h0000;
			lpc_tick    <= 1'b0;
			lpc_sel_ext <= 1'b0;
		end else begin
			lpc_sel_ext <= use_ext; // R17
			lpc_tick    <= 1'b0;
			if (use_ext) begin
				lpc_tick <= lpc_rise; // R17
			end else if (lpc_div_reg == LPC_DIV[15:0] - 16'h0001) begin
				lpc_div_reg <= 16'h0000;
				lpc_tick    <= 1'b1; // R18
			end else begin
				lpc_div_reg <= lpc_div_reg + 16'h0001;
			end
		end
	end

	// Read mux
	// Read data is zero outside a read access phase
	always @* begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
				`RCRC_OFF_CTRL:   prdata = ctrl_reg;
				`RCRC_OFF_STATUS: prdata = {24'h0, lpc_sel_ext, src_reg, det_ok_reg,
					(st_reg == ST_DONE), comb_reg, pol_reg, awake_reg};
				`RCRC_OFF_FREQ:   prdata = ref_freq_khz;
				`RCRC_OFF_TRIM:   prdata = {16'h0, freq_trim};
				`RCRC_OFF_NVCFG:  prdata = {29'h0, lpcp_sync_reg[1], nvt_sync_reg[1],
					nvf_sync_reg[1]};
				`RCRC_OFF_DIVCFG: prdata = {24'h0, div_reg};
				default:          prdata = 32'h0000_0000;
			endcase
		end
	end

endmodule
`default_nettype wire

//--- testbench/rcrc_req_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcrc_defines.vh"
module rcrc_req_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        request_polarity_strap,
	input wire logic        request_combine_strap,
	input wire logic        clk_req_in,
	input wire logic        clk_req_out,
	input wire logic        clk_req_oe,
	input wire logic [31:0] ref_freq_khz,
	input wire logic [15:0] freq_trim,
	input wire logic [47:0] synth_word
);
	logic [2:0] age;
	wire up = (age == 3'h7);
	wire pol = request_polarity_strap;
	wire comb = request_combine_strap;
	wire wr_ctrl = psel && penable && pwrite && (paddr == `RCRC_OFF_CTRL);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Straps settle a few cycles after reset, so gate strap-based checks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			age <= 3'h0;
		else if (!up)
			age <= age + 3'h1;
	end
	chk_comb_or_gate: assert property (up && comb && pol && clk_req_in |-> clk_req_out)
		else $error("combined request lost its external half");
	chk_comb_and_gate: assert property (up && comb && !pol && !clk_req_in |-> !clk_req_out)
		else $error("active-low combine output high with input low");
	chk_input_ignored: assert property (up && !comb && !$past(wr_ctrl) && !$past(wr_ctrl, 2)
		|-> clk_req_out == $past(clk_req_out))
		else $error("request output moved without a control write");
	chk_awake_follows: assert property (up && !comb && $past(wr_ctrl, 2) && !$past(wr_ctrl)
		|-> clk_req_out == ($past(pwdata[0], 2) ~^ pol))
		else $error("request output does not follow awake state");
	chk_pin_release: assert property (up && $past(wr_ctrl, 2) && !$past(wr_ctrl)
		|-> clk_req_oe == !$past(pwdata[1], 2))
		else $error("pin enable does not follow release bit");
	chk_default_freq: assert property ($rose(presetn)
		|-> ref_freq_khz == `RCRC_FREQ_DEFAULT && freq_trim == `RCRC_TRIM_RESET)
		else $error("reset frequency or trim wrong");
	chk_synth_trim: assert property (synth_word ==
		({ref_freq_khz, 16'h0000} + {{32{freq_trim[15]}}, freq_trim}))
		else $error("synth word does not carry trim");
	chk_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	chk_unmapped_err: assert property (psel && penable && paddr > `RCRC_OFF_DIVCFG |-> pslverr)
		else $error("unmapped access not refused");
	chk_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
		else $error("read data outside read access");
	cover property (up && comb && clk_req_out);
	cover property (wr_ctrl);
	cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

//--- testbench/rcrc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module rcrc_far_side (
	input wire logic  want,
	input wire logic  pol,
	input wire logic  present,
	output logic      clk_req_in,
	output var logic  lpc
);
	logic run = 1'b0;
	// Request always at a defined level, already in output polarity
	assign clk_req_in = want ~^ pol;
	// Free-running 32.768 kHz low-power clock, steady whenever present
	always #15259 run = ~run;
	assign lpc = run & present;
endmodule
`default_nettype wire

//--- testbench/test_ref_clock_request_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcrc_defines.vh"
module test_ref_clock_request_control;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, exb;
	logic        pol = 0, comb = 0, want = 0, nv_v = 0, lpc_on = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, q, ef;
	wire  [31:0] prdata, ref_freq_khz;
	wire  [15:0] freq_trim;
	wire  [47:0] synth_word;
	wire         pready, pslverr, clk_req_in, clk_req_out, clk_req_oe, lpc, bt, lt, lsel;
	int          fail_count = 0, check_count = 0, i, a, w, n;
	rcrc_ref_clock_request_control #(.DET_PERIODS(2), .LPC_DIV(4)) rcrc_ref_clock_request_control_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.request_polarity_strap(pol), .request_combine_strap(comb), .clk_req_in(clk_req_in),
		.clk_req_out(clk_req_out), .clk_req_oe(clk_req_oe), .nv_valid(nv_v),
		.nv_freq_present(nv_v), .nv_freq_khz(32'h0000_9600), .nv_trim_present(nv_v),
		.nv_trim(16'h0005), .low_power_clock_ext(lpc), .lpc_ext_present(lpc_on),
		.ref_freq_khz(ref_freq_khz), .freq_trim(freq_trim), .synth_word(synth_word),
		.bit_tick(bt), .lpc_tick(lt), .lpc_sel_ext(lsel));
	rcrc_far_side rcrc_far_side_inst (.want(want), .pol(pol), .present(lpc_on),
		.clk_req_in(clk_req_in), .lpc(lpc));
	always #25 pclk = ~pclk;
	task automatic bad(input string m);
		fail_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [47:0] g, input logic [47:0] x, input string m);
		check_count++;
		if (g !== x) bad(m);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One APB transfer; holds the request until ready is seen
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		int k;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, ad, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			bad("bus timeout");
			tally_and_finish;
		end
	endtask
	// Edges between two pulses of a tick output, sampled off the launch edge
	task automatic tick_gap(input logic pick, input int x, input string m);
		int c, t0, t1;
		c = 0;
		t0 = -1;
		t1 = -1;
		while (t1 < 0 && c < 6000) begin
			@(negedge pclk);
			c++;
			if ((pick ? lt : bt) === 1'b1) begin
				if (t0 < 0) t0 = c;
				else t1 = c;
			end
		end
		if (t1 >= 0) begin
			chk(t1 - t0, x, m);
		end else begin
			bad("tick timeout");
			tally_and_finish;
		end
	endtask
	// Each pass: new straps and boot source, then pin, trim and bus checks
	initial begin
		for (i = 0; i < 4; i++) begin
			presetn <= 0;
			{comb, pol} <= i[1:0];
			nv_v <= (i == 0);
			lpc_on <= (i == 2);
			repeat (20) @(posedge pclk);
			presetn <= 1;
			n = 0;
			do begin
				apb(0, `RCRC_OFF_STATUS, 32'h0000_0000);
				n++;
			end while (q[3] !== 1'b1 && n < 1000);
			if (n >= 1000) begin
				bad("config timeout");
				tally_and_finish;
			end
			chk(q[6:5], (i == 0) ? 1 : (i == 2) ? 2 : 0, "boot source");
			ef = (i == 0) ? 32'h0000_9600 : 32'h0000_4E20;
			apb(0, `RCRC_OFF_FREQ, 32'h0000_0000);
			if (i == 2) begin
				check_count++;
				if (q < 19960 || q > 20040) bad("detected frequency");
			end else begin
				chk(q, ef, "frequency reg");
				chk(ref_freq_khz, ef, "frequency out");
			end
			chk(freq_trim, (i == 0) ? 5 : 0, "boot trim");
			tick_gap(1, 4, "internal low-power tick");
			if (i != 2) tick_gap(0, (ef >> 4) + 1, "bit timing");
			for (a = 0; a < 2; a++) begin
				for (w = 0; w < 2; w++) begin
					want <= w[0];
					apb(1, `RCRC_OFF_CTRL, a);
					repeat (3) @(posedge pclk);
					exb = comb ? (pol ? (w[0] | a[0]) : (!w[0] & !a[0])) : (a[0] ~^ pol);
					chk(clk_req_out, exb, "request pin");
				end
			end
			apb(1, `RCRC_OFF_CTRL, 32'h0000_0007);
			repeat (3) @(posedge pclk);
			chk(clk_req_oe, 0, "pin release");
			chk(lsel, i == 2, "low-power clock source");
			apb(1, `RCRC_OFF_TRIM, 32'h0000_FFF0);
			repeat (3) @(posedge pclk);
			chk(freq_trim, 16'hFFF0, "host trim");
			if (i != 2) chk(synth_word, {ef, 16'h0000} - 48'h10, "synth trim");
			apb(1, `RCRC_OFF_DIVCFG, 32'h0000_0000);
			apb(0, `RCRC_OFF_DIVCFG, 32'h0000_0000);
			chk(q, 1, "zero divisor");
			apb(1, `RCRC_OFF_DIVCFG, 32'h0000_0002);
			if (i != 2) tick_gap(0, (ef >> 4) / 2 + 1, "divided bit timing");
			apb(0, 12'h018, 32'h0000_0000);
			chk(e, 1, "unmapped refused");
		end
		tally_and_finish;
	end
endmodule
bind rcrc_ref_clock_request_control rcrc_req_checker rcrc_req_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.request_polarity_strap(request_polarity_strap), .clk_req_in(clk_req_in),
	.request_combine_strap(request_combine_strap), .clk_req_out(clk_req_out),
	.clk_req_oe(clk_req_oe), .ref_freq_khz(ref_freq_khz), .freq_trim(freq_trim),
	.synth_word(synth_word));
`default_nettype wire
